// [hdl/rsf_defines.svh]
// Register offsets, field positions, reset values and timing counts
// Behaviour
// - Bandgap powered while low-voltage reset is enabled or buffer enable is set.
// - Buffer enable is read/write bit 3 of bandgap control, reset value 0.
// - Real undervoltage reset sets its flag; only software clears it.
// - Undefined low-voltage control code sets its flag; only software clears it.
// - Watchdog time-out in FAST or SLOW sets time-out flag and resets fully.
// - Watchdog time-out in SLEEP or IDLE clears only PC and SP, sets time-out.
// - Power-on reset clears time-out and power-down flags.
// - Undervoltage reset in FAST or SLOW leaves both status flags unchanged.
// - Normal-mode watchdog reset sets time-out, keeps power-down flag.
// - Idle or sleep watchdog reset leaves time-out and power-down at 1.
// - After power-on every interrupt source stays disabled until software enables.
// - After power-on watchdog and time bases clear, watchdog restarts counting.
// - After power-on the timer module is switched off.
// - After power-on every port pin is an input.
// - After power-on stack pointer at top, execution from address zero.
// - Full resets load watchdog 53, low-voltage 5a, port A ff; idle watchdog reset keeps all three.
// - Invalid watchdog enable code sets its flag; only software clears it.
// - Other low-voltage codes cause delayed reset restoring the register.
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH
`define RSF_OFS_BANDGAP    12'h000
`define RSF_OFS_FLAGS      12'h004
`define RSF_OFS_WDT_CTRL   12'h008
`define RSF_OFS_LV_CTRL    12'h00c
`define RSF_OFS_STATUS     12'h010
`define RSF_OFS_IRQ_STAT   12'h014
`define RSF_OFS_IRQ_EN     12'h018
`define RSF_OFS_IRQ_CLR    12'h01c
`define RSF_OFS_CORE       12'h020
`define RSF_BIT_BG_EN      3
`define RSF_BIT_UV_FLAG    2
`define RSF_BIT_LVC_FLAG   1
`define RSF_BIT_WDC_FLAG   0
`define RSF_BIT_TIMEOUT    1
`define RSF_BIT_PDOWN      0
`define RSF_RST_WDT_CTRL   8'h53
`define RSF_RST_LV_CTRL    8'h5a
`define RSF_LV_DISABLE     8'ha5
`define RSF_WE_ENABLE      5'h0a
`define RSF_WE_DISABLE     5'h15
`define RSF_RST_PORT_A     8'hff
`define RSF_SRESET_NS      1000
`define RSF_CLK_NS         10
`define RSF_SRESET_CYC     ((`RSF_SRESET_NS + `RSF_CLK_NS - 1) / `RSF_CLK_NS)
`endif

// [hdl/rsf_pkg.sv]
// Types shared by the reset-source block
package rsf_pkg;
  typedef enum logic [1:0] {
    RSF_RUN_FAST,
    RSF_RUN_SLOW,
    RSF_IDLE,
    RSF_SLEEP
  } rsf_mode_type;
  typedef enum logic [1:0] {
    RSF_NONE,
    RSF_FULL,
    RSF_PARTIAL
  } rsf_rst_type;
endpackage

// [hdl/rsf_sync.sv]
// Two-flop synchroniser for asynchronous event inputs
module rsf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  initial begin
    if (WIDTH < 1) $error("rsf_sync: WIDTH must be positive");
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [hdl/rsf_delay.sv]
// Delay timer that fires after a request has held for COUNT cycles, and again every COUNT cycles while it holds
module rsf_delay #(
  parameter int COUNT = 100
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request and firing
  input  wire logic req,
  output logic      fire
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt_r;
  initial begin
    if (COUNT < 1) $error("rsf_delay: COUNT must be at least one");
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      fire  <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!req) begin
        cnt_r <= '0;
      end else if (cnt_r == CW'(COUNT - 1)) begin
        cnt_r <= '0;
        fire  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end
endmodule

// [hdl/rsf_top.sv]
// Reset-source flags, reset-state loader and APB registers
//
// Local design decisions: the APB interface to the registers and the register offsets.
`include "rsf_defines.svh"
module rsf_top import rsf_pkg::*; #(
  parameter int PC_W = 11,
  parameter int SP_W = 3,
  parameter int SRESET_CYC = `RSF_SRESET_CYC
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources, asynchronous
  input  wire logic        undervolt_evt,
  input  wire logic        wdt_timeout_evt,
  // Core state
  input  wire logic [1:0]  cpu_mode,
  input  wire logic        halt_evt,
  // Reset-state outputs
  output logic             core_rst_req,
  output logic [PC_W-1:0]  pc_load,
  output logic [SP_W-1:0]  sp_load,
  output logic             int_global_en,
  output logic             wdt_cnt_clear,
  output logic             tb_cnt_clear,
  output logic             timer_on,
  output logic [7:0]       port_a_data,
  output logic [7:0]       port_a_direction,
  output logic [7:0]       watchdog_control,
  output logic [7:0]       lowvolt_control,
  output logic             bandgap_on,
  output logic             irq
);
  initial begin
    if (PC_W < 1 || PC_W > 16 || SP_W < 1 || SP_W > 8)
      $error("rsf_top: unsupported counter widths");
  end

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bg_en;
    logic        uv_flag;
    logic        lvc_flag;
    logic        wdc_flag;
    logic        timeout;
    logic        pdown;
    logic [7:0]  wdt_ctrl;
    logic [7:0]  lv_ctrl;
    logic [7:0]  pa_data;
    logic [7:0]  pa_dir;
    logic        int_en;
    logic        timer_on;
    logic        cnt_clear;
    logic        core_rst;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_en;
    logic        irq;
    logic        bg_on;
  } rsf_state_type;

  rsf_state_type st_r, st_nxt;
  logic          uv_s, wdt_s;
  logic          uv_d_r, wdt_d_r;
  logic          lvc_bad, wdc_bad;
  logic          lvc_fire, wdc_fire;
  rsf_mode_type  mode;

  function automatic logic lv_code_bad(input logic [7:0] v);
    return v != `RSF_RST_LV_CTRL && v != `RSF_LV_DISABLE;
  endfunction

  function automatic logic wdt_code_bad(input logic [7:0] v);
    return v[7:3] != `RSF_WE_ENABLE && v[7:3] != `RSF_WE_DISABLE;
  endfunction

  assign mode = rsf_mode_type'(cpu_mode);
  assign lvc_bad = lv_code_bad(st_r.lv_ctrl);
  assign wdc_bad = wdt_code_bad(st_r.wdt_ctrl);

  rsf_sync #(.WIDTH(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({undervolt_evt, wdt_timeout_evt}),
    .q       ({uv_s, wdt_s})
  );

  // Bad codes must persist for the delay; a rewrite in time cancels it
  rsf_delay #(.COUNT(SRESET_CYC)) u_lvc_dly (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (lvc_bad),
    .fire    (lvc_fire)
  );
  rsf_delay #(.COUNT(SRESET_CYC)) u_wdc_dly (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (wdc_bad),
    .fire    (wdc_fire)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_d_r  <= 1'b0;
      wdt_d_r <= 1'b0;
    end else begin
      uv_d_r  <= uv_s;
      wdt_d_r <= wdt_s;
    end
  end

  logic uv_rise, wdt_rise, sleepish, wdt_full, wdt_part, full_rst;
  logic apb_acc, apb_wr;
  assign uv_rise  = uv_s & ~uv_d_r;
  assign wdt_rise = wdt_s & ~wdt_d_r;
  assign sleepish = (mode == RSF_IDLE) || (mode == RSF_SLEEP);
  assign wdt_full = wdt_rise & ~sleepish;
  assign wdt_part = wdt_rise & sleepish;
  // Low-voltage reset is off in sleep or idle
  assign full_rst = wdt_full | (uv_rise & ~sleepish) | lvc_fire | wdc_fire;
  assign apb_acc  = psel & penable & ~st_r.pready;
  assign apb_wr   = apb_acc & pwrite;

  always_comb begin
    logic [31:0] rd;
    logic [2:0]  evt;
    rd = 32'h0;
    evt = {uv_rise & ~sleepish, lvc_fire, wdc_fire};
    st_nxt = st_r;
    st_nxt.cnt_clear = 1'b0;
    st_nxt.core_rst  = 1'b0;
    st_nxt.pready    = apb_acc;
    st_nxt.pslverr   = 1'b0;
    st_nxt.prdata    = 32'h0;
    if (apb_acc) begin
      unique case (paddr)
        `RSF_OFS_BANDGAP:  rd[`RSF_BIT_BG_EN] = st_r.bg_en;
        `RSF_OFS_FLAGS:    rd[2:0] = {st_r.uv_flag, st_r.lvc_flag,
                                      st_r.wdc_flag};
        `RSF_OFS_WDT_CTRL: rd[7:0] = st_r.wdt_ctrl;
        `RSF_OFS_LV_CTRL:  rd[7:0] = st_r.lv_ctrl;
        `RSF_OFS_STATUS:   rd[1:0] = {st_r.timeout, st_r.pdown};
        `RSF_OFS_IRQ_STAT: rd[2:0] = st_r.irq_stat;
        `RSF_OFS_IRQ_EN:   rd[2:0] = st_r.irq_en;
        `RSF_OFS_IRQ_CLR:  rd = 32'h0;
        `RSF_OFS_CORE:     rd[2:0] = {st_r.timer_on, st_r.int_en,
                                      st_r.bg_on};
        default:           st_nxt.pslverr = 1'b1;
      endcase
      if (!pwrite) begin
        st_nxt.prdata = rd;
      end
    end
    if (apb_wr) begin
      unique case (paddr)
        `RSF_OFS_BANDGAP:  st_nxt.bg_en = pwdata[`RSF_BIT_BG_EN];
        `RSF_OFS_FLAGS: begin
          // Writing 0 clears; writing 1 leaves the flag
          st_nxt.uv_flag  = st_r.uv_flag  & pwdata[`RSF_BIT_UV_FLAG];
          st_nxt.lvc_flag = st_r.lvc_flag & pwdata[`RSF_BIT_LVC_FLAG];
          st_nxt.wdc_flag = st_r.wdc_flag & pwdata[`RSF_BIT_WDC_FLAG];
        end
        `RSF_OFS_WDT_CTRL: st_nxt.wdt_ctrl = pwdata[7:0];
        `RSF_OFS_LV_CTRL:  st_nxt.lv_ctrl = pwdata[7:0];
        `RSF_OFS_IRQ_EN:   st_nxt.irq_en = pwdata[2:0];
        `RSF_OFS_IRQ_CLR:  st_nxt.irq_stat = st_r.irq_stat & ~pwdata[2:0];
        `RSF_OFS_CORE: begin
          st_nxt.int_en   = pwdata[1];
          st_nxt.timer_on = pwdata[2];
        end
        default: ;
      endcase
    end
    if (halt_evt) begin
      st_nxt.pdown = 1'b1;
    end
    // Set after the clear so a colliding event is kept
    if (uv_rise & ~sleepish) st_nxt.uv_flag = 1'b1;
    if (lvc_fire) st_nxt.lvc_flag = 1'b1;
    if (wdc_fire) st_nxt.wdc_flag = 1'b1;
    st_nxt.irq_stat = st_nxt.irq_stat | evt;
    if (full_rst) begin
      st_nxt.core_rst  = 1'b1;
      st_nxt.cnt_clear = 1'b1;
      st_nxt.int_en    = 1'b0;
      st_nxt.timer_on  = 1'b0;
      st_nxt.wdt_ctrl  = `RSF_RST_WDT_CTRL;
      st_nxt.lv_ctrl   = `RSF_RST_LV_CTRL;
      st_nxt.pa_data   = `RSF_RST_PORT_A;
      st_nxt.pa_dir    = `RSF_RST_PORT_A;
      st_nxt.bg_en     = 1'b0;
    end
    // Undervoltage reset leaves both status flags alone
    if (wdt_full) st_nxt.timeout = 1'b1;
    if (wdt_part) begin
      st_nxt.core_rst = 1'b1;
      st_nxt.timeout  = 1'b1;
      st_nxt.pdown    = 1'b1;
    end
    st_nxt.irq   = |(st_nxt.irq_stat & st_nxt.irq_en);
    st_nxt.bg_on = st_nxt.bg_en | (st_nxt.lv_ctrl != `RSF_LV_DISABLE);
  end

  // Power-on: flags cleared, interrupts off, timer off, ports input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= '0;
      st_r.wdt_ctrl  <= `RSF_RST_WDT_CTRL;
      st_r.lv_ctrl   <= `RSF_RST_LV_CTRL;
      st_r.pa_data   <= `RSF_RST_PORT_A;
      st_r.pa_dir    <= `RSF_RST_PORT_A;
      st_r.cnt_clear <= 1'b1;
      st_r.core_rst  <= 1'b1;
      st_r.bg_on     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign core_rst_req     = st_r.core_rst;
  assign pc_load          = '0;
  assign sp_load          = '0;
  assign int_global_en    = st_r.int_en;
  assign wdt_cnt_clear    = st_r.cnt_clear;
  assign tb_cnt_clear     = st_r.cnt_clear;
  assign timer_on         = st_r.timer_on;
  assign port_a_data      = st_r.pa_data;
  assign port_a_direction = st_r.pa_dir;
  assign watchdog_control = st_r.wdt_ctrl;
  assign lowvolt_control  = st_r.lv_ctrl;
  assign bandgap_on       = st_r.bg_on;
  assign irq              = st_r.irq;

  a_bg_power: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.bg_en |-> bandgap_on) else $error("bandgap off while enabled");
  a_wdt_normal: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_full |=> st_r.timeout && core_rst_req && port_a_direction == 8'hff)
    else $error("normal watchdog reset wrong");
  a_wdt_idle: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_part && !full_rst |=> st_r.timeout && st_r.pdown &&
    $stable(port_a_direction)) else $error("idle watchdog reset wrong");
  a_uv_keep: assert property (@(posedge pclk) disable iff (!presetn)
    uv_rise && !wdt_rise && !halt_evt |=> $stable(st_r.timeout) &&
    $stable(st_r.pdown)) else $error("status changed by undervoltage");
  a_uv_flag: assert property (@(posedge pclk) disable iff (!presetn)
    uv_rise && !sleepish |=> st_r.uv_flag) else $error("uv flag lost");
  a_lvc_flag: assert property (@(posedge pclk) disable iff (!presetn)
    lvc_fire |=> st_r.lvc_flag && lowvolt_control == 8'h5a)
    else $error("code reset flag lost");
  a_wdc_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wdc_fire |=> st_r.wdc_flag) else $error("watchdog code flag lost");
  a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.uv_flag && !apb_wr |=> st_r.uv_flag)
    else $error("uv flag cleared by hardware");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(st_nxt.irq_stat) & $past(st_nxt.irq_en)))
    else $error("irq mismatch");
endmodule

// [testbench/rsf_top_tb.sv]
// Self-checking bench for the reset-source flags block
`include "rsf_defines.svh"
module rsf_top_tb import rsf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic        undervolt_evt, wdt_timeout_evt, halt_evt;
  logic [1:0]  cpu_mode;
  logic        core_rst_req, int_global_en, wdt_cnt_clear, tb_cnt_clear;
  logic        timer_on, bandgap_on, irq;
  logic [10:0] pc_load;
  logic [2:0]  sp_load;
  logic [7:0]  port_a_data, port_a_direction;
  logic [7:0]  watchdog_control, lowvolt_control;
  int          fails, total_checks, rst_seen, clr_seen;

  rsf_top #(.SRESET_CYC(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .undervolt_evt(undervolt_evt),
    .wdt_timeout_evt(wdt_timeout_evt), .cpu_mode(cpu_mode),
    .halt_evt(halt_evt), .core_rst_req(core_rst_req), .pc_load(pc_load),
    .sp_load(sp_load), .int_global_en(int_global_en),
    .wdt_cnt_clear(wdt_cnt_clear), .tb_cnt_clear(tb_cnt_clear),
    .timer_on(timer_on), .port_a_data(port_a_data),
    .port_a_direction(port_a_direction),
    .watchdog_control(watchdog_control),
    .lowvolt_control(lowvolt_control), .bandgap_on(bandgap_on), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Pulses counted here so short reset strobes are never missed
  always @(posedge pclk) begin
    if (core_rst_req === 1'b1) rst_seen++;
    if (wdt_cnt_clear === 1'b1 && tb_cnt_clear === 1'b1) clr_seen++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Master holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit: only the watchdog below ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd, e, msg);
  endtask

  // Events are asynchronous; held long enough to cross the synchroniser
  task automatic pulse_evt(input bit wdt);
    @(posedge pclk);
    if (wdt) wdt_timeout_evt <= 1'b1; else undervolt_evt <= 1'b1;
    repeat (4) @(posedge pclk);
    wdt_timeout_evt <= 1'b0; undervolt_evt <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask

  task automatic power_on();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic t_power_on();
    chk(watchdog_control, 8'h53, "wdt ctrl");
    chk(lowvolt_control, 8'h5a, "lv ctrl");
    chk({port_a_data, port_a_direction}, 16'hffff, "port a");
    chk({pc_load, sp_load}, 14'h0, "pc sp");
    chk({int_global_en, timer_on}, 2'b00, "int timer");
    rdchk(`RSF_OFS_BANDGAP, 32'h0, "bandgap rst");
    rdchk(`RSF_OFS_STATUS, 32'h0, "status rst");
    rdchk(`RSF_OFS_FLAGS, 32'h0, "flags rst");
    apb(1'b1, 12'h100, 32'h1);
    chk(err, 1'b1, "unmapped");
  endtask

  task automatic t_bandgap();
    apb(1'b1, `RSF_OFS_BANDGAP, 32'h8);
    rdchk(`RSF_OFS_BANDGAP, 32'h8, "bg rw");
    apb(1'b1, `RSF_OFS_LV_CTRL, 32'ha5);
    repeat (2) @(posedge pclk);
    chk(bandgap_on, 1'b1, "bg by enable");
    apb(1'b1, `RSF_OFS_BANDGAP, 32'h0);
    repeat (2) @(posedge pclk);
    chk(bandgap_on, 1'b0, "bg off");
    apb(1'b1, `RSF_OFS_LV_CTRL, 32'h5a);
    repeat (2) @(posedge pclk);
    chk(bandgap_on, 1'b1, "bg by lv");
  endtask

  // Normal watchdog, then halt, then undervoltage while flags stand
  task automatic t_normal();
    apb(1'b1, `RSF_OFS_CORE, 32'h6);
    apb(1'b1, `RSF_OFS_WDT_CTRL, 32'h57);
    clr_seen = 0;
    pulse_evt(1'b1);
    rdchk(`RSF_OFS_STATUS, 32'h2, "wdt normal");
    chk(watchdog_control, 8'h53, "wdt reload");
    chk({int_global_en, timer_on}, 2'b00, "full rst");
    chk(clr_seen > 0, 1'b1, "cnt clear");
    @(posedge pclk);
    halt_evt <= 1'b1;
    @(posedge pclk);
    halt_evt <= 1'b0;
    pulse_evt(1'b0);
    rdchk(`RSF_OFS_STATUS, 32'h3, "uv keeps");
    rdchk(`RSF_OFS_FLAGS, 32'h4, "uv flag");
    apb(1'b1, `RSF_OFS_FLAGS, 32'h0);
    rdchk(`RSF_OFS_FLAGS, 32'h0, "uv clear");
  endtask

  task automatic t_idle();
    power_on();
    apb(1'b1, `RSF_OFS_CORE, 32'h6);
    apb(1'b1, `RSF_OFS_WDT_CTRL, 32'h57);
    cpu_mode <= RSF_IDLE;
    @(posedge pclk);
    halt_evt <= 1'b1;
    @(posedge pclk);
    halt_evt <= 1'b0;
    rst_seen = 0;
    pulse_evt(1'b1);
    chk(rst_seen > 0, 1'b1, "pc sp reload");
    chk(watchdog_control, 8'h57, "idle keeps wdt");
    chk({int_global_en, timer_on}, 2'b11, "idle keeps");
    rdchk(`RSF_OFS_STATUS, 32'h3, "wdt idle");
    cpu_mode <= RSF_RUN_FAST;
  endtask

  // Bad codes force a delayed reset; irq then masked, raised, cleared
  task automatic t_codes();
    apb(1'b1, `RSF_OFS_LV_CTRL, 32'h33);
    repeat (20) @(posedge pclk);
    chk(lowvolt_control, 8'h5a, "lv restore");
    apb(1'b1, `RSF_OFS_WDT_CTRL, 32'h03);
    repeat (20) @(posedge pclk);
    rdchk(`RSF_OFS_FLAGS, 32'h3, "code flags");
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, `RSF_OFS_IRQ_EN, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1, "irq on");
    apb(1'b1, `RSF_OFS_IRQ_CLR, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq clear");
    rdchk(`RSF_OFS_IRQ_STAT, 32'h1, "irq stat");
  endtask

  task automatic results();
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #100us;
    fails++;
    results();
  end

  initial begin
    fails = 0; total_checks = 0; rst_seen = 0; clr_seen = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; undervolt_evt = 1'b0;
    wdt_timeout_evt = 1'b0; halt_evt = 1'b0; cpu_mode = RSF_RUN_FAST;
    power_on();
    t_power_on();
    t_bandgap();
    t_normal();
    t_idle();
    t_codes();
    results();
  end
endmodule
